//--- src/nss_node_setup.sv
`timescale 1ns/1ps
// Behaviour
// - Only reports data, never drives external systems
// - Power lamp steady; heartbeat shows state
// - Heartbeat dark on internal communication failure
// - Heartbeat steady, normal, no host traffic
// - Heartbeat flashes on detected host traffic
// - Heartbeat fades in bootloader state
// - Selector 0 maps 100, 1-7 direct
// - Else software node value; serial last two digits (00 is 100) when it is unset
// - Switch changes apply only after restart
// - Switch 1 protocol, switch 2 temperature unit
// - Modbus TCP always enabled
// - Switches 3,4: current loop or pulse
// - Switch 5 off permits bootloading
// - Switch 6 cloud reporting; 7 reserved
// - Switch 8 picks node address source
// - Same data layout for both protocols
// - PROFINET little-endian, EtherNet/IP big-endian
// - Factory network defaults as listed
// - Onboard electronics temperature channel provided
module nss_node_setup #(
  parameter int unsigned FLASH_HALF = nss_pkg::FLASH_HALF_CYC,
  parameter int unsigned ACT_HOLD = nss_pkg::ACT_HOLD_CYC,
  parameter int unsigned FADE_STEP = nss_pkg::FADE_STEP_CYC,
  parameter int unsigned DEBOUNCE = nss_pkg::DEBOUNCE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] setting_switch_bank,
  input wire logic [2:0] node_number_selector,
  input wire logic [3:0] serial_tens,
  input wire logic [3:0] serial_ones,
  input wire logic comm_ok,
  input wire logic host_traffic,
  input wire logic boot_mode,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic power_indicator,
  output logic heartbeat_indicator,
  output logic proto_enip,
  output logic modbus_tcp_enable,
  output logic temp_fahrenheit,
  output logic ch1_pulse_mode,
  output logic ch2_pulse_mode,
  output logic boot_permit,
  output logic cloud_report_enable,
  output logic node_from_internal,
  output logic [6:0] node_number,
  output logic big_endian,
  output logic internal_temp_enable,
  output logic cfg_valid
);
  import nss_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [7:0] sw_s1;
    logic [7:0] sw_s2;
    logic [2:0] sel_s1;
    logic [2:0] sel_s2;
    logic [3:0] ten_s1;
    logic [3:0] ten_s2;
    logic [3:0] one_s1;
    logic [3:0] one_s2;
    logic comm_s1;
    logic comm_s2;
    logic act_s1;
    logic act_s2;
    logic act_prev;
    logic boot_s1;
    logic boot_s2;
    logic [18:0] stable_t;
    logic [17:0] db_cnt;
    logic loaded;
    logic [7:0] sw_hold;
    logic [6:0] node_hold;
    logic [6:0] soft_node;
    logic [31:0] net_addr;
    logic [31:0] net_mask;
    logic [31:0] net_gw;
    logic [31:0] net_dns1;
    logic [31:0] net_dns2;
    logic [31:0] swap_in;
    logic [27:0] act_cnt;
    logic [24:0] flash_cnt;
    logic flash_ph;
    logic [13:0] fade_div;
    logic [7:0] fade_lvl;
    logic fade_up;
    logic [7:0] pwm_cnt;
    logic hb;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } nss_state_t;

  nss_state_t state_q;
  nss_state_t state_d;
  nss_hb_mode_t hb_mode;
  logic [31:0] swapped;
  function automatic logic [6:0] sel_to_node(input logic [2:0] pos);
    sel_to_node = (pos == 3'h0) ? NODE_ZERO_MAP : {4'h0, pos};
  endfunction : sel_to_node

  function automatic logic [6:0] serial_to_node(input logic [3:0] tens,
                                                input logic [3:0] ones);
    logic [6:0] v;
    v = 7'(tens) * 7'h0A + 7'(ones);
    serial_to_node = (v == 7'h00) ? NODE_MAX : v;
  endfunction : serial_to_node

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // ==========================================================================
  // Heartbeat mode selection
  // ==========================================================================
  always_comb begin
    if (!state_q.comm_s2) begin
      hb_mode = HB_DARK;
    end else if (state_q.boot_s2) begin
      hb_mode = HB_FADE;
    end else if (state_q.act_cnt != 28'h000_0000) begin
      hb_mode = HB_FLASH;
    end else begin
      hb_mode = HB_STEADY;
    end
  end

  // Same layout either protocol; only byte order inside the word differs
  always_comb begin
    if (state_q.sw_hold[SW_PROTO_BIT]) begin
      swapped = {state_q.swap_in[7:0], state_q.swap_in[15:8],
                 state_q.swap_in[23:16], state_q.swap_in[31:24]};
    end else begin
      swapped = state_q.swap_in;
    end
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic stable;
    logic [7:0] rd_addr;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    stable = 1'b0;
    rd_addr = 8'h00;
    aw_hs = 1'b0;
    w_hs = 1'b0;
    ar_hs = 1'b0;
    state_d = state_q;

    // Two-flop synchronisers on every outside level
    state_d.sw_s1 = setting_switch_bank;
    state_d.sw_s2 = state_q.sw_s1;
    state_d.sel_s1 = node_number_selector;
    state_d.sel_s2 = state_q.sel_s1;
    state_d.ten_s1 = serial_tens;
    state_d.ten_s2 = state_q.ten_s1;
    state_d.one_s1 = serial_ones;
    state_d.one_s2 = state_q.one_s1;
    state_d.comm_s1 = comm_ok;
    state_d.comm_s2 = state_q.comm_s1;
    state_d.act_s1 = host_traffic;
    state_d.act_s2 = state_q.act_s1;
    state_d.act_prev = state_q.act_s2;
    state_d.boot_s1 = boot_mode;
    state_d.boot_s2 = state_q.boot_s1;

    // Debounce: inputs must hold still for DEBOUNCE cycles before capture
    state_d.stable_t = {state_q.sw_s2, state_q.sel_s2, state_q.ten_s2,
                        state_q.one_s2[3:0]};
    stable = (state_d.stable_t == state_q.stable_t);
    if (!state_q.loaded) begin
      if (!stable) begin
        state_d.db_cnt = 18'h0_0000;
      end else if (state_q.db_cnt >= 18'(DEBOUNCE - 1)) begin
        // One capture per reset; later switch moves are ignored
        state_d.loaded = 1'b1;
        state_d.sw_hold = state_q.sw_s2;
        if (state_q.sw_s2[SW_NODE_INT_BIT]) begin
          state_d.node_hold = serial_to_node(state_q.ten_s2, state_q.one_s2);
        end else begin
          state_d.node_hold = sel_to_node(state_q.sel_s2);
        end
      end else begin
        state_d.db_cnt = state_q.db_cnt + 18'h0_0001;
      end
    end

    // Host traffic retriggers the flash window
    if (state_q.act_s2 && !state_q.act_prev) begin
      state_d.act_cnt = 28'(ACT_HOLD);
    end else if (state_q.act_cnt != 28'h000_0000) begin
      state_d.act_cnt = state_q.act_cnt - 28'h000_0001;
    end

    if (state_q.flash_cnt >= 25'(FLASH_HALF - 1)) begin
      state_d.flash_cnt = 25'h000_0000;
      state_d.flash_ph = ~state_q.flash_ph;
    end else begin
      state_d.flash_cnt = state_q.flash_cnt + 25'h000_0001;
    end

    // Fade: triangle duty ramp driving a PWM
    state_d.pwm_cnt = state_q.pwm_cnt + 8'h01;
    if (state_q.fade_div >= 14'(FADE_STEP - 1)) begin
      state_d.fade_div = 14'h0000;
      if (state_q.fade_up) begin
        state_d.fade_lvl = state_q.fade_lvl + 8'h01;
        state_d.fade_up = (state_q.fade_lvl != 8'hFE);
      end else begin
        state_d.fade_lvl = state_q.fade_lvl - 8'h01;
        state_d.fade_up = (state_q.fade_lvl == 8'h01);
      end
    end else begin
      state_d.fade_div = state_q.fade_div + 14'h0001;
    end

    case (hb_mode)
      HB_DARK: state_d.hb = 1'b0;
      HB_STEADY: state_d.hb = 1'b1;
      HB_FLASH: state_d.hb = state_q.flash_ph;
      HB_FADE: state_d.hb = (state_q.pwm_cnt < state_q.fade_lvl);
      default: state_d.hb = 1'b0;
    endcase

    // AXI4-Lite write: address and data taken in either order
    aw_hs = s_axi_awvalid && !state_q.aw_got && !state_q.bvalid;
    w_hs = s_axi_wvalid && !state_q.w_got && !state_q.bvalid;
    if (aw_hs) begin
      state_d.aw_got = 1'b1;
      state_d.aw_addr = s_axi_awaddr[7:0];
    end
    if (w_hs) begin
      state_d.w_got = 1'b1;
      state_d.w_data = s_axi_wdata;
      state_d.w_strb = s_axi_wstrb;
    end
    if (state_q.aw_got && state_q.w_got) begin
      state_d.aw_got = 1'b0;
      state_d.w_got = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp = RESP_OKAY;
      case (state_q.aw_addr)
        REG_NET_ADDR: state_d.net_addr = merge(state_q.net_addr, state_q.w_data,
                                               state_q.w_strb);
        REG_NET_MASK: state_d.net_mask = merge(state_q.net_mask, state_q.w_data,
                                               state_q.w_strb);
        REG_NET_GW: state_d.net_gw = merge(state_q.net_gw, state_q.w_data,
                                           state_q.w_strb);
        REG_NET_DNS1: state_d.net_dns1 = merge(state_q.net_dns1, state_q.w_data,
                                               state_q.w_strb);
        REG_NET_DNS2: state_d.net_dns2 = merge(state_q.net_dns2, state_q.w_data,
                                               state_q.w_strb);
        REG_SOFT_NODE: begin
          if (state_q.w_strb[0]) begin
            state_d.soft_node = state_q.w_data[6:0];
          end
        end
        REG_SWAP_IN: state_d.swap_in = merge(state_q.swap_in, state_q.w_data,
                                             state_q.w_strb);
        REG_CFG, REG_NODE, REG_STATE, REG_SWAP_OUT: state_d.bresp = RESP_OKAY;
        default: state_d.bresp = RESP_SLVERR;
      endcase
    end
    if (state_q.bvalid && s_axi_bready) begin
      state_d.bvalid = 1'b0;
    end

    // AXI4-Lite read: one-cycle decode into the read data flop
    ar_hs = s_axi_arvalid && !state_q.rvalid;
    rd_addr = s_axi_araddr[7:0];
    if (ar_hs) begin
      state_d.rvalid = 1'b1;
      state_d.rresp = RESP_OKAY;
      case (rd_addr)
        REG_CFG: state_d.rdata = {23'h00_0000, state_q.loaded, state_q.sw_hold};
        REG_NODE: state_d.rdata = {25'h000_0000, node_number};
        REG_STATE: state_d.rdata = {30'h0000_0000, state_q.boot_s2, state_q.comm_s2};
        REG_NET_ADDR: state_d.rdata = state_q.net_addr;
        REG_NET_MASK: state_d.rdata = state_q.net_mask;
        REG_NET_GW: state_d.rdata = state_q.net_gw;
        REG_NET_DNS1: state_d.rdata = state_q.net_dns1;
        REG_NET_DNS2: state_d.rdata = state_q.net_dns2;
        REG_SOFT_NODE: state_d.rdata = {25'h000_0000, state_q.soft_node};
        REG_SWAP_IN: state_d.rdata = state_q.swap_in;
        REG_SWAP_OUT: state_d.rdata = swapped;
        default: begin
          state_d.rdata = 32'h0000_0000;
          state_d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (state_q.rvalid && s_axi_rready) begin
      state_d.rvalid = 1'b0;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= '0;
      state_q.fade_up <= 1'b1;
      state_q.soft_node <= SOFT_NODE_RST;
      state_q.net_addr <= NET_ADDR_RST;
      state_q.net_mask <= NET_MASK_RST;
      state_q.net_gw <= NET_GW_RST;
      state_q.net_dns1 <= NET_DNS1_RST;
      state_q.net_dns2 <= NET_DNS2_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign s_axi_awready = !state_q.aw_got && !state_q.bvalid;
  assign s_axi_wready = !state_q.w_got && !state_q.bvalid;
  assign s_axi_bvalid = state_q.bvalid;
  assign s_axi_bresp = state_q.bresp;
  assign s_axi_arready = !state_q.rvalid;
  assign s_axi_rvalid = state_q.rvalid;
  assign s_axi_rdata = state_q.rdata;
  assign s_axi_rresp = state_q.rresp;

  // Power lamp tracks reset release; no output commands outside plant
  assign power_indicator = aresetn;
  assign heartbeat_indicator = state_q.hb;
  assign modbus_tcp_enable = 1'b1;
  assign internal_temp_enable = 1'b1;
  assign cfg_valid = state_q.loaded;
  assign proto_enip = state_q.sw_hold[SW_PROTO_BIT];
  assign temp_fahrenheit = state_q.sw_hold[SW_FAHR_BIT];
  assign ch1_pulse_mode = state_q.sw_hold[SW_CH1_PULSE_BIT];
  assign ch2_pulse_mode = state_q.sw_hold[SW_CH2_PULSE_BIT];
  // Held at zero before capture, so bootloading is permitted: factory off
  assign boot_permit = !state_q.sw_hold[SW_BOOT_BLOCK_BIT];
  assign cloud_report_enable = !state_q.sw_hold[SW_CLOUD_OFF_BIT];
  assign node_from_internal = state_q.sw_hold[SW_NODE_INT_BIT];
  // Internal source prefers the software value; serial default when unset
  assign node_number = (state_q.sw_hold[SW_NODE_INT_BIT] &&
                        state_q.soft_node != 7'h00 &&
                        state_q.soft_node <= NODE_MAX) ?
                       state_q.soft_node : state_q.node_hold;
  assign big_endian = state_q.sw_hold[SW_PROTO_BIT];

endmodule : nss_node_setup

//--- src/nss_pkg.sv
package nss_pkg;

  // ==========================================================================
  // Switch bank bit positions (switch n sits at bit n-1)
  // ==========================================================================
  localparam int unsigned SW_PROTO_BIT = 0;
  localparam int unsigned SW_FAHR_BIT = 1;
  localparam int unsigned SW_CH1_PULSE_BIT = 2;
  localparam int unsigned SW_CH2_PULSE_BIT = 3;
  localparam int unsigned SW_BOOT_BLOCK_BIT = 4;
  localparam int unsigned SW_CLOUD_OFF_BIT = 5;
  localparam int unsigned SW_RESERVED_BIT = 6;
  localparam int unsigned SW_NODE_INT_BIT = 7;

  // ==========================================================================
  // Node numbers
  // ==========================================================================
  localparam logic [6:0] NODE_ZERO_MAP = 7'h64;
  localparam logic [6:0] NODE_MAX = 7'h64;

  // ==========================================================================
  // Factory network defaults
  // ==========================================================================
  localparam logic [31:0] NET_ADDR_RST = 32'hC0A8_0164;
  localparam logic [31:0] NET_MASK_RST = 32'hFFFF_FF00;
  localparam logic [31:0] NET_GW_RST = 32'hC0A8_0101;
  localparam logic [31:0] NET_DNS1_RST = 32'h0000_0000;
  localparam logic [31:0] NET_DNS2_RST = 32'h0000_0001;

  // ==========================================================================
  // AXI4-Lite register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_NODE = 8'h04;
  localparam logic [7:0] REG_STATE = 8'h08;
  localparam logic [7:0] REG_NET_ADDR = 8'h0C;
  localparam logic [7:0] REG_NET_MASK = 8'h10;
  localparam logic [7:0] REG_NET_GW = 8'h14;
  localparam logic [7:0] REG_NET_DNS1 = 8'h18;
  localparam logic [7:0] REG_NET_DNS2 = 8'h1C;
  localparam logic [7:0] REG_SOFT_NODE = 8'h20;
  localparam logic [7:0] REG_SWAP_IN = 8'h24;
  localparam logic [7:0] REG_SWAP_OUT = 8'h28;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // STATE register: [0] comm_ok, [1] boot_mode
  localparam logic [6:0] SOFT_NODE_RST = 7'h01;

  // ==========================================================================
  // Timing (200 MHz clock)
  // ==========================================================================
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned FLASH_HALF_MS = 100;
  localparam int unsigned FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int unsigned ACT_HOLD_MS = 1000;
  localparam int unsigned ACT_HOLD_CYC = CLK_HZ / 1000 * ACT_HOLD_MS;
  localparam int unsigned FADE_STEP_US = 50;
  localparam int unsigned FADE_STEP_CYC = CLK_HZ / 1_000_000 * FADE_STEP_US;
  localparam int unsigned DEBOUNCE_US = 100;
  localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1_000_000 * DEBOUNCE_US;

  typedef enum logic [1:0] {
    HB_DARK,
    HB_STEADY,
    HB_FLASH,
    HB_FADE
  } nss_hb_mode_t;

endpackage : nss_pkg

//--- tb/nss_node_setup_props.sv
`timescale 1ns/1ps
module nss_node_setup_props
  import nss_pkg::*;
#(
  parameter int unsigned ACT_HOLD = 40
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic comm_ok,
  input wire logic host_traffic,
  input wire logic boot_mode,
  input wire logic power_indicator,
  input wire logic heartbeat_indicator,
  input wire logic proto_enip,
  input wire logic modbus_tcp_enable,
  input wire logic temp_fahrenheit,
  input wire logic ch1_pulse_mode,
  input wire logic ch2_pulse_mode,
  input wire logic boot_permit,
  input wire logic cloud_report_enable,
  input wire logic node_from_internal,
  input wire logic [6:0] node_number,
  input wire logic big_endian,
  input wire logic internal_temp_enable,
  input wire logic cfg_valid
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [31:0] quiet_q;
  logic [13:0] cfg_w;
  assign cfg_w = {proto_enip, temp_fahrenheit, ch1_pulse_mode, ch2_pulse_mode, boot_permit,
    cloud_report_enable, node_from_internal, node_from_internal ? 7'h00 : node_number};

  // Cycles of healthy, idle, non-boot state seen at the inputs
  always_ff @(posedge aclk) begin
    if (!aresetn || !comm_ok || boot_mode || host_traffic) begin
      quiet_q <= '0;
    end else begin
      quiet_q <= quiet_q + 32'd1;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  AST_PWR_ON: assert property (power_indicator)
    else $error("power lamp dark out of reset");
  AST_MODBUS_ON: assert property (modbus_tcp_enable)
    else $error("modbus disabled");
  AST_ITEMP_ON: assert property (internal_temp_enable)
    else $error("onboard temperature channel off");
  AST_ENDIAN: assert property (big_endian == proto_enip)
    else $error("byte order does not follow protocol");
  AST_CFG_HOLD: assert property (cfg_valid ##1 cfg_valid |-> $stable(cfg_w))
    else $error("captured setup changed without restart");
  AST_NODE_SEL: assert property (cfg_valid && !node_from_internal |->
    node_number inside {[7'h01:7'h07], 7'h64})
    else $error("selector node number out of map");
  AST_NODE_RANGE: assert property (cfg_valid |-> node_number inside {[7'h01:7'h64]})
    else $error("node number outside 1 to 100");
  AST_HB_DARK: assert property (!comm_ok [*5] |-> !heartbeat_indicator)
    else $error("heartbeat lit without internal comms");
  AST_HB_STEADY: assert property (quiet_q > 32'(ACT_HOLD) + 32'd8 |-> heartbeat_indicator)
    else $error("heartbeat not steady when idle");
  // Bound of 10 assumes the short flash half period used in simulation
  AST_HB_FLASH: assert property ((comm_ok && !boot_mode && $rose(host_traffic)) ##1
    (comm_ok && !boot_mode) [*3] |-> ##[1:10] $changed(heartbeat_indicator))
    else $error("heartbeat not flashing on host traffic");

  COV_FLASH: cover property ($rose(host_traffic) && comm_ok);
  COV_FADE: cover property ((boot_mode && comm_ok) [*8]);
  COV_INT_SRC: cover property (cfg_valid && node_from_internal);
endmodule : nss_node_setup_props

bind nss_node_setup nss_node_setup_props #(.ACT_HOLD(ACT_HOLD)) u_props (
  .aclk, .aresetn, .comm_ok, .host_traffic, .boot_mode, .power_indicator,
  .heartbeat_indicator, .proto_enip, .modbus_tcp_enable, .temp_fahrenheit,
  .ch1_pulse_mode, .ch2_pulse_mode, .boot_permit, .cloud_report_enable,
  .node_from_internal, .node_number, .big_endian, .internal_temp_enable, .cfg_valid
);

//--- tb/nss_host_model.sv
`timescale 1ns/1ps
module nss_host_model (
  input wire logic aclk,
  input wire logic poll,
  input wire logic slow,
  output logic host_traffic
);
  // A poll shows as a burst of link activity; a slow host keeps it up longer
  int left;
  initial begin
    host_traffic = 1'b0;
    left = 0;
  end
  always @(posedge aclk) begin
    if (poll) begin
      left <= slow ? 12 : 2;
    end else if (left > 0) begin
      left <= left - 1;
    end
    host_traffic <= poll || (left > 1);
  end
endmodule : nss_host_model

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  import nss_pkg::*;
  localparam int unsigned ACT = 40;
  logic aclk, aresetn, comm_ok, host_traffic, boot_mode, poll, slow;
  logic [7:0] setting_switch_bank;
  logic [2:0] node_number_selector;
  logic [3:0] serial_tens, serial_ones, s_axi_wstrb;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic power_indicator, heartbeat_indicator, proto_enip, modbus_tcp_enable;
  logic temp_fahrenheit, ch1_pulse_mode, ch2_pulse_mode, boot_permit;
  logic cloud_report_enable, node_from_internal, big_endian, internal_temp_enable;
  logic cfg_valid;
  logic [6:0] node_number;
  int errors, compares, cyc;

  nss_node_setup #(.FLASH_HALF(4), .ACT_HOLD(ACT), .FADE_STEP(2), .DEBOUNCE(3)) uut (
    .aclk, .aresetn, .setting_switch_bank, .node_number_selector, .serial_tens,
    .serial_ones, .comm_ok, .host_traffic, .boot_mode, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .power_indicator, .heartbeat_indicator, .proto_enip, .modbus_tcp_enable,
    .temp_fahrenheit, .ch1_pulse_mode, .ch2_pulse_mode, .boot_permit,
    .cloud_report_enable, .node_from_internal, .node_number, .big_endian,
    .internal_temp_enable, .cfg_valid
  );
  nss_host_model u_host (.aclk, .poll, .slow, .host_traffic);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic end_sim();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Soft node register restarts at a valid value, so switch 8 on gives it
  function automatic logic [6:0] exp_node(input logic [7:0] b, input logic [2:0] s);
    if (b[7]) return 7'h01;
    return (s == 3'h0) ? 7'h64 : {4'h0, s};
  endfunction : exp_node

  function automatic logic [6:0] exp_ser(input logic [3:0] t, input logic [3:0] o);
    return (t == 4'h0 && o == 4'h0) ? 7'h64 : 7'(10 * t + o);
  endfunction : exp_ser

  function automatic logic [31:0] exp_swap(input logic enip, input logic [31:0] d);
    return enip ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
  endfunction : exp_swap

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= {24'h0000_00, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask : wr

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    s_axi_araddr <= {24'h0000_00, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(nm, e, s_axi_rdata);
    chk(nm, {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rc

  task automatic chk_cfg(input logic [7:0] b, input logic [2:0] s);
    chk("cfg_valid", 1, cfg_valid);
    chk("proto", b[0], proto_enip);
    chk("fahr", b[1], temp_fahrenheit);
    chk("ch1", b[2], ch1_pulse_mode);
    chk("ch2", b[3], ch2_pulse_mode);
    chk("boot", !b[4], boot_permit);
    chk("cloud", !b[5], cloud_report_enable);
    chk("nsrc", b[7], node_from_internal);
    chk("endian", b[0], big_endian);
    chk("modbus", 1, modbus_tcp_enable);
    chk("itemp", 1, internal_temp_enable);
    chk("node", exp_node(b, s), node_number);
  endtask : chk_cfg

  task automatic restart(input logic [7:0] b, input logic [2:0] s);
    aresetn <= 1'b0;
    setting_switch_bank <= b;
    node_number_selector <= s;
    serial_tens <= 4'($urandom_range(9));
    serial_ones <= 4'($urandom_range(9));
    repeat (20) @(posedge aclk);
    chk("pwr_rst", 0, power_indicator);
    aresetn <= 1'b1;
    repeat (40) if (cfg_valid !== 1'b1) @(posedge aclk);
    repeat (2) @(posedge aclk);
    chk("pwr", 1, power_indicator);
  endtask : restart

  task automatic levels(input int n, output int hi, output int lo);
    hi = 0;
    lo = 0;
    repeat (n) begin
      @(posedge aclk);
      if (heartbeat_indicator === 1'b1) hi++;
      else if (heartbeat_indicator === 1'b0) lo++;
    end
  endtask : levels

  always @(posedge aclk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      $display("mismatch timeout expected %0d seen %0d", 20000, cyc);
      end_sim();
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [7:0] b;
    logic [2:0] s;
    logic [31:0] d;
    logic [1:0] r;
    logic [31:0] net [5];
    int hi, lo;
    net = '{32'hC0A8_0164, 32'hFFFF_FF00, 32'hC0A8_0101, 32'h0000_0000, 32'h0000_0001};
    void'($urandom(32'h17d6));
    {aresetn, comm_ok, boot_mode, poll, slow} = 5'b01000;
    {setting_switch_bank, node_number_selector, serial_tens, serial_ones} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    for (int i = 0; i < 6; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      s = (i == 0) ? 3'h0 : (i == 2) ? 3'h7 : 3'($urandom);
      restart(b, s);
      chk_cfg(b, s);
      setting_switch_bank <= ~b;
      node_number_selector <= s + 3'h1;
      repeat (20) @(posedge aclk);
      chk_cfg(b, s);
      rc("cfg", REG_CFG, {23'h0, 1'b1, b}, RESP_OKAY);
      rc("node", REG_NODE, {25'h0, exp_node(b, s)}, RESP_OKAY);
      for (int k = 0; k < 5; k++) rc("net", REG_NET_ADDR + 8'(4 * k), net[k], RESP_OKAY);
      d = $urandom;
      wr(REG_SWAP_IN, d, r);
      rc("swap", REG_SWAP_OUT, exp_swap(b[0], d), RESP_OKAY);
      wr(REG_CFG, ~d, r);
      chk("ro_resp", {30'h0, RESP_OKAY}, {30'h0, r});
      rc("cfg_ro", REG_CFG, {23'h0, 1'b1, b}, RESP_OKAY);
      wr(8'h40, d, r);
      chk("unmap_wr", {30'h0, RESP_SLVERR}, {30'h0, r});
      rc("unmap_rd", 8'h40, 32'h0, RESP_SLVERR);
      if (b[7]) wr(REG_SOFT_NODE, 32'h0, r);
      if (b[7]) chk("node_ser", exp_ser(serial_tens, serial_ones), node_number);
    end
    comm_ok <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("hb_dark", 0, heartbeat_indicator);
    comm_ok <= 1'b1;
    repeat (ACT + 12) @(posedge aclk);
    chk("hb_steady", 1, heartbeat_indicator);
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      poll <= 1'b1;
      @(posedge aclk);
      poll <= 1'b0;
      levels(30, hi, lo);
      chk("hb_flash", 1, hi > 0 && lo > 0);
    end
    boot_mode <= 1'b1;
    levels(2000, hi, lo);
    chk("hb_fade", 1, hi > 0 && lo > 0);
    boot_mode <= 1'b0;
    end_sim();
  end
endmodule : tb
